// ### pkg/spm_gpio_consts.vh
// Constants for the shared pin mux and general-purpose port block.
//
// Behaviour
// - Every shared pin except port C pin 1 has its own select bit, direction bit and data bit.
// - With the port selected, a direction bit of 0 makes the pin an input and 1 an output.
// - An input pin reads back its sampled level and an output pin is driven by its data bit.
// - Data and direction bits act on a pin only while the port function is selected on it.
// - Select A bits 0 to 3 at 1 route port A pins to analog inputs 0, 1, 9 and 8.
// - Select A bits 8 to 15 at 1 give the PWM, timer compare, timer direction and clock pins.
// - Select B bit 0 gives the ADC start input and bits 4 to 7 give the capture inputs.
// - Select B bits 2 and 3 are inverted: 1 gives port C bits 2 and 3, 0 the flag and branch.
// - Port C pin 1 ignores select B bit 1 and follows the clock output selector.
// - Selector 00 gives port C bit 1, 01 watchdog, 10 system and 11 CPU clock.
// - In each port register the data bit of pin n is bit n and its direction bit n plus 8.
// - The registers decode at 7090h, 7092h, 7098h, 709Ah and 709Ch.
// - The registers are read and written by plain processor data accesses.
// - Both select registers are fully read/write, reserved bits included, and reset to 0.
// - Every port direction and data bit resets to 0, so each pin starts as input except C2 and C3, with their peripheral, and C1 when the selector is not 00.
`ifndef SPM_GPIO_CONSTS_VH
`define SPM_GPIO_CONSTS_VH

`define SPM_ADDR_SELECT_A 16'h7090
`define SPM_ADDR_SELECT_B 16'h7092
`define SPM_ADDR_PORT_A 16'h7098
`define SPM_ADDR_PORT_B 16'h709a
`define SPM_ADDR_PORT_C 16'h709c

`define SPM_RESET_SELECT 16'h0000
`define SPM_RESET_PORT 16'h0000
`define SPM_RDATA_NONE 16'h0000

`define SPM_PORT_A_MASK 16'h0f0f
`define SPM_DIR_POS 8
`define SPM_PORT_B_SEL_POS 8

`define SPM_PIN_C1 13
`define SPM_CLKSEL_PORT 2'b00
`define SPM_CLKSEL_WATCHDOG 2'b01
`define SPM_CLKSEL_SYSTEM 2'b10
`define SPM_CLKSEL_CPU 2'b11

`endif

// ### design/spm_pin_cell.v
// One shared pin: chooses between the port bit and the peripheral.
`timescale 1ns/100ps
module spm_pin_cell
(
    input wire i_port_sel,
    input wire i_dir,
    input wire i_data,
    input wire i_per_out,
    input wire i_per_oe,
    output reg o_pin_out,
    output reg o_pin_oe_n
);

////////////////////////////////////////////////////////////////////////////////
// Output value and enable of the pin.
always @*
begin
    if (i_port_sel)
    begin
        o_pin_out = i_data;
        o_pin_oe_n = ~i_dir;
    end
    else
    begin
        o_pin_out = i_per_out;
        o_pin_oe_n = ~i_per_oe;
    end
end

endmodule // spm_pin_cell

// ### design/spm_gpio.v
// Shared pin multiplexer and general-purpose ports A, B and C.
`timescale 1ns/100ps
`include "spm_gpio_consts.vh"
module spm_gpio
#(
    parameter NUM_A = 4,
    parameter NUM_B = 8,
    parameter NUM_C = 8
)
(
    input wire i_clock,
    input wire i_rst_n,
    input wire [15:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr_en,
    input wire i_rd_en,
    output wire [15:0] o_rdata,
    input wire [1:0] i_clock_output_selector,
    input wire i_watchdog_clock,
    input wire i_system_clock,
    input wire i_cpu_clock,
    input wire [NUM_A-1:0] i_port_a_pin,
    output wire [NUM_A-1:0] o_port_a_pin,
    output wire [NUM_A-1:0] o_port_a_oe_n,
    input wire [NUM_B-1:0] i_port_b_pin,
    output wire [NUM_B-1:0] o_port_b_pin,
    output wire [NUM_B-1:0] o_port_b_oe_n,
    input wire [NUM_C-1:0] i_port_c_pin,
    output wire [NUM_C-1:0] o_port_c_pin,
    output wire [NUM_C-1:0] o_port_c_oe_n,
    input wire [NUM_A-1:0] i_per_a_out,
    input wire [NUM_A-1:0] i_per_a_oe,
    output wire [NUM_A-1:0] o_per_a_in,
    input wire [NUM_B-1:0] i_per_b_out,
    input wire [NUM_B-1:0] i_per_b_oe,
    output wire [NUM_B-1:0] o_per_b_in,
    input wire [NUM_C-1:0] i_per_c_out,
    input wire [NUM_C-1:0] i_per_c_oe,
    output wire [NUM_C-1:0] o_per_c_in
);

localparam NUM_PINS = NUM_A + NUM_B + NUM_C;
localparam NUM_SYNC = NUM_PINS + 3;
localparam BASE_B = NUM_A;
localparam BASE_C = NUM_A + NUM_B;

////////////////////////////////////////////////////////////////////////////////
// Register state.
reg [15:0] pin_select_a_ff;
reg [15:0] nxt_pin_select_a;
reg [15:0] pin_select_b_ff;
reg [15:0] nxt_pin_select_b;
reg [15:0] port_a_data_direction_ff;
reg [15:0] nxt_port_a_data_direction;
reg [15:0] port_b_data_direction_ff;
reg [15:0] nxt_port_b_data_direction;
reg [15:0] port_c_data_direction_ff;
reg [15:0] nxt_port_c_data_direction;
reg [15:0] rdata_ff;
reg [15:0] nxt_rdata;

////////////////////////////////////////////////////////////////////////////////
// Synchronisers and pin output flops.
reg [NUM_SYNC-1:0] sync1_ff;
reg [NUM_SYNC-1:0] sync2_ff;
reg [NUM_PINS-1:0] pin_out_ff;
reg [NUM_PINS-1:0] pin_oe_n_ff;

wire [NUM_SYNC-1:0] raw_in;
wire [NUM_PINS-1:0] pin_level;
wire watchdog_clock_sync;
wire system_clock_sync;
wire cpu_clock_sync;

////////////////////////////////////////////////////////////////////////////////
// Per-pin control vectors.
wire [NUM_PINS-1:0] port_sel;
wire [NUM_PINS-1:0] dir_bits;
wire [NUM_PINS-1:0] data_bits;
wire [NUM_PINS-1:0] per_out;
wire [NUM_PINS-1:0] per_oe;
wire [NUM_PINS-1:0] nxt_pin_out;
wire [NUM_PINS-1:0] nxt_pin_oe_n;
wire [NUM_PINS-1:0] read_bits;
reg clock_out_value;
wire clock_out_on;

////////////////////////////////////////////////////////////////////////////////
// Address decode.
wire hit_select_a;
wire hit_select_b;
wire hit_port_a;
wire hit_port_b;
wire hit_port_c;

assign hit_select_a = (i_addr == `SPM_ADDR_SELECT_A);
assign hit_select_b = (i_addr == `SPM_ADDR_SELECT_B);
assign hit_port_a = (i_addr == `SPM_ADDR_PORT_A);
assign hit_port_b = (i_addr == `SPM_ADDR_PORT_B);
assign hit_port_c = (i_addr == `SPM_ADDR_PORT_C);

////////////////////////////////////////////////////////////////////////////////
// Register writes by the processor.
// Writes to unmapped addresses change nothing.
always @*
begin
    nxt_pin_select_a = pin_select_a_ff;
    nxt_pin_select_b = pin_select_b_ff;
    nxt_port_a_data_direction = port_a_data_direction_ff;
    nxt_port_b_data_direction = port_b_data_direction_ff;
    nxt_port_c_data_direction = port_c_data_direction_ff;
    if (i_wr_en)
    begin
        if (hit_select_a)
        begin
            nxt_pin_select_a = i_wdata;
        end
        if (hit_select_b)
        begin
            nxt_pin_select_b = i_wdata;
        end
        // Port A keeps only its four data bits and four direction bits.
        if (hit_port_a)
        begin
            nxt_port_a_data_direction = i_wdata & `SPM_PORT_A_MASK;
        end
        if (hit_port_b)
        begin
            nxt_port_b_data_direction = i_wdata;
        end
        if (hit_port_c)
        begin
            nxt_port_c_data_direction = i_wdata;
        end
    end
end

always @(posedge i_clock or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        pin_select_a_ff <= `SPM_RESET_SELECT;
        pin_select_b_ff <= `SPM_RESET_SELECT;
        port_a_data_direction_ff <= `SPM_RESET_PORT;
        port_b_data_direction_ff <= `SPM_RESET_PORT;
        port_c_data_direction_ff <= `SPM_RESET_PORT;
    end
    else
    begin
        pin_select_a_ff <= nxt_pin_select_a;
        pin_select_b_ff <= nxt_pin_select_b;
        port_a_data_direction_ff <= nxt_port_a_data_direction;
        port_b_data_direction_ff <= nxt_port_b_data_direction;
        port_c_data_direction_ff <= nxt_port_c_data_direction;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Two-flop synchronisers for pin levels and the three clocks.
// Only the second flop of each pair is read by any logic.
assign raw_in = {i_cpu_clock, i_system_clock, i_watchdog_clock,
                 i_port_c_pin, i_port_b_pin, i_port_a_pin};

always @(posedge i_clock or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        sync1_ff <= {NUM_SYNC{1'b0}};
        sync2_ff <= {NUM_SYNC{1'b0}};
    end
    else
    begin
        sync1_ff <= raw_in;
        sync2_ff <= sync1_ff;
    end
end

assign pin_level = sync2_ff[NUM_PINS-1:0];
assign watchdog_clock_sync = sync2_ff[NUM_PINS];
assign system_clock_sync = sync2_ff[NUM_PINS+1];
assign cpu_clock_sync = sync2_ff[NUM_PINS+2];

////////////////////////////////////////////////////////////////////////////////
// Port selection per pin.
assign port_sel[BASE_B-1:0] = ~pin_select_a_ff[NUM_A-1:0];
assign port_sel[BASE_C-1:BASE_B] =
    ~pin_select_a_ff[`SPM_PORT_B_SEL_POS+NUM_B-1:`SPM_PORT_B_SEL_POS];
assign port_sel[BASE_C] = ~pin_select_b_ff[0];
// Select B bit 1 is stored but steers no pin.
assign port_sel[`SPM_PIN_C1] = ~clock_out_on;
// Pins C2 and C3 use inverted select bits and so come up owned by their peripheral.
assign port_sel[BASE_C+2] = pin_select_b_ff[2];
assign port_sel[BASE_C+3] = pin_select_b_ff[3];
assign port_sel[NUM_PINS-1:BASE_C+4] = ~pin_select_b_ff[NUM_C-1:4];

////////////////////////////////////////////////////////////////////////////////
// Clock output selection on port C pin 1.
// The clocks are sampled on this clock, so a source faster than half its rate aliases.
assign clock_out_on = (i_clock_output_selector != `SPM_CLKSEL_PORT);

always @*
begin
    case (i_clock_output_selector)
        `SPM_CLKSEL_WATCHDOG:
        begin
            clock_out_value = watchdog_clock_sync;
        end
        `SPM_CLKSEL_SYSTEM:
        begin
            clock_out_value = system_clock_sync;
        end
        `SPM_CLKSEL_CPU:
        begin
            clock_out_value = cpu_clock_sync;
        end
        default:
        begin
            clock_out_value = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Direction, data and peripheral vectors.
assign dir_bits = {port_c_data_direction_ff[`SPM_DIR_POS+NUM_C-1:`SPM_DIR_POS],
                   port_b_data_direction_ff[`SPM_DIR_POS+NUM_B-1:`SPM_DIR_POS],
                   port_a_data_direction_ff[`SPM_DIR_POS+NUM_A-1:`SPM_DIR_POS]};
assign data_bits = {port_c_data_direction_ff[NUM_C-1:0],
                    port_b_data_direction_ff[NUM_B-1:0],
                    port_a_data_direction_ff[NUM_A-1:0]};

// Pin C1 takes no peripheral drive: it carries the clock output whenever one is chosen.
assign per_out[BASE_C-1:0] = {i_per_b_out, i_per_a_out};
assign per_out[BASE_C] = i_per_c_out[0];
assign per_out[`SPM_PIN_C1] = clock_out_value;
assign per_out[NUM_PINS-1:`SPM_PIN_C1+1] = i_per_c_out[NUM_C-1:2];
assign per_oe[BASE_C-1:0] = {i_per_b_oe, i_per_a_oe};
assign per_oe[BASE_C] = i_per_c_oe[0];
assign per_oe[`SPM_PIN_C1] = 1'b1;
assign per_oe[NUM_PINS-1:`SPM_PIN_C1+1] = i_per_c_oe[NUM_C-1:2];

////////////////////////////////////////////////////////////////////////////////
// One pin cell per shared pin.
// An output pin reads back its data bit and an input pin its synchronised level.
genvar gi;
generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1)
    begin : g_pin
        spm_pin_cell u_cell
        (
            .i_port_sel(port_sel[gi]),
            .i_dir(dir_bits[gi]),
            .i_data(data_bits[gi]),
            .i_per_out(per_out[gi]),
            .i_per_oe(per_oe[gi]),
            .o_pin_out(nxt_pin_out[gi]),
            .o_pin_oe_n(nxt_pin_oe_n[gi])
        );
        assign read_bits[gi] = dir_bits[gi] ? data_bits[gi] : pin_level[gi];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Registered pin drive.
// Flops keep decode glitches off the pads and give every pin the same delay.
always @(posedge i_clock or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        pin_out_ff <= {NUM_PINS{1'b0}};
        pin_oe_n_ff <= {NUM_PINS{1'b1}};
    end
    else
    begin
        pin_out_ff <= nxt_pin_out;
        pin_oe_n_ff <= nxt_pin_oe_n;
    end
end

assign o_port_a_pin = pin_out_ff[BASE_B-1:0];
assign o_port_a_oe_n = pin_oe_n_ff[BASE_B-1:0];
assign o_port_b_pin = pin_out_ff[BASE_C-1:BASE_B];
assign o_port_b_oe_n = pin_oe_n_ff[BASE_C-1:BASE_B];
assign o_port_c_pin = pin_out_ff[NUM_PINS-1:BASE_C];
assign o_port_c_oe_n = pin_oe_n_ff[NUM_PINS-1:BASE_C];

// Peripherals always see the sampled pin level.
assign o_per_a_in = pin_level[BASE_B-1:0];
assign o_per_b_in = pin_level[BASE_C-1:BASE_B];
assign o_per_c_in = pin_level[NUM_PINS-1:BASE_C];

////////////////////////////////////////////////////////////////////////////////
// Register reads.
// Unmapped reads return zero, and read data stands until the next read strobe.
always @*
begin
    nxt_rdata = rdata_ff;
    if (i_rd_en)
    begin
        if (hit_select_a)
        begin
            nxt_rdata = pin_select_a_ff;
        end
        else if (hit_select_b)
        begin
            nxt_rdata = pin_select_b_ff;
        end
        else if (hit_port_a)
        begin
            nxt_rdata = {port_a_data_direction_ff[15:NUM_A],
                         read_bits[BASE_B-1:0]};
        end
        else if (hit_port_b)
        begin
            nxt_rdata = {port_b_data_direction_ff[15:NUM_B],
                         read_bits[BASE_C-1:BASE_B]};
        end
        else if (hit_port_c)
        begin
            nxt_rdata = {port_c_data_direction_ff[15:NUM_C],
                         read_bits[NUM_PINS-1:BASE_C]};
        end
        else
        begin
            nxt_rdata = `SPM_RDATA_NONE;
        end
    end
end

always @(posedge i_clock or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        rdata_ff <= `SPM_RDATA_NONE;
    end
    else
    begin
        rdata_ff <= nxt_rdata;
    end
end

assign o_rdata = rdata_ff;

endmodule // spm_gpio

// ### test/spm_gpio_properties.sv
// Checker for the shared pin mux and port block.
`timescale 1ns/100ps
`include "spm_gpio_consts.vh"
module spm_gpio_properties
(
    input wire i_clock,
    input wire i_rst_n,
    input wire [15:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [15:0] o_rdata,
    input wire [1:0] i_clock_output_selector,
    input wire i_watchdog_clock,
    input wire i_system_clock,
    input wire i_cpu_clock,
    input wire [3:0] i_port_a_pin,
    input wire [3:0] o_per_a_in,
    input wire [7:0] i_port_c_pin,
    input wire [7:0] o_per_c_in,
    input wire [3:0] o_port_a_oe_n,
    input wire [7:0] i_port_b_pin,
    input wire [7:0] o_port_b_pin,
    input wire [7:0] o_port_b_oe_n,
    input wire [7:0] o_port_c_pin,
    input wire [7:0] o_port_c_oe_n,
    input wire [3:0] i_per_a_oe,
    input wire [7:0] i_per_b_out,
    input wire [7:0] i_per_b_oe,
    input wire [7:0] o_per_b_in,
    input wire [7:0] i_per_c_oe,
    input wire [7:0] i_per_c_out
);
////////////////////////////////////////////////////////////////////////////////
// Shadow copies of the registers, and a settle counter after reset.
reg [15:0] sa_ff;
reg [15:0] sb_ff;
reg [15:0] pa_ff;
reg [15:0] pb_ff;
reg [15:0] pc_ff;
reg [1:0] up_ff;
wire rdy = (up_ff == 2'b11);
wire [7:0] own_c = {sb_ff[7:4], ~sb_ff[3:2], 1'b0, sb_ff[0]};
wire clk_pick = (i_clock_output_selector == 2'b01) ? i_watchdog_clock :
    (i_clock_output_selector == 2'b10) ? i_system_clock : i_cpu_clock;
wire mapped = (i_addr == `SPM_ADDR_SELECT_A) || (i_addr == `SPM_ADDR_SELECT_B) ||
    (i_addr == `SPM_ADDR_PORT_A) || (i_addr == `SPM_ADDR_PORT_B) || (i_addr == `SPM_ADDR_PORT_C);
always @(posedge i_clock or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        sa_ff <= 16'h0000;
        sb_ff <= 16'h0000;
        pa_ff <= 16'h0000;
        pb_ff <= 16'h0000;
        pc_ff <= 16'h0000;
        up_ff <= 2'b00;
    end
    else
    begin
        if (up_ff != 2'b11) up_ff <= up_ff + 2'b01;
        if (i_wr_en && i_addr == `SPM_ADDR_SELECT_A) sa_ff <= i_wdata;
        if (i_wr_en && i_addr == `SPM_ADDR_SELECT_B) sb_ff <= i_wdata;
        if (i_wr_en && i_addr == `SPM_ADDR_PORT_A) pa_ff <= i_wdata & 16'h0f0f;
        if (i_wr_en && i_addr == `SPM_ADDR_PORT_B) pb_ff <= i_wdata;
        if (i_wr_en && i_addr == `SPM_ADDR_PORT_C) pc_ff <= i_wdata;
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge i_clock); endclocking
default disable iff (!i_rst_n);
sequence s_wr(a); i_wr_en && i_addr == a; endsequence
sequence s_rd(a); i_rd_en && !i_wr_en && i_addr == a; endsequence
sequence s_idle; !i_wr_en && !i_rd_en; endsequence
property p_sel_a_rb;
    s_wr(`SPM_ADDR_SELECT_A) ##1 s_idle ##1 s_rd(`SPM_ADDR_SELECT_A)
        |=> o_rdata == $past(i_wdata, 3);
endproperty
a_sel_a_rb: assert property (p_sel_a_rb) else $error("select A readback wrong");
property p_sel_b_rb;
    s_wr(`SPM_ADDR_SELECT_B) ##1 s_idle ##1 s_rd(`SPM_ADDR_SELECT_B)
        |=> o_rdata == $past(i_wdata, 3);
endproperty
a_sel_b_rb: assert property (p_sel_b_rb) else $error("select B readback wrong");
property p_unmapped;
    i_rd_en && !mapped |=> o_rdata == 16'h0000;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
property p_rd_hold;
    !i_rd_en |=> $stable(o_rdata);
endproperty
a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
property p_per_in;
    rdy |-> (o_per_b_in == $past(i_port_b_pin, 2)) && (o_per_a_in == $past(i_port_a_pin, 2))
        && (o_per_c_in == $past(i_port_c_pin, 2));
endproperty
a_per_in: assert property (p_per_in) else $error("pin level not forwarded");
property p_a_oe;
    rdy |-> o_port_a_oe_n == ~$past((sa_ff[3:0] & i_per_a_oe) | (~sa_ff[3:0] & pa_ff[11:8]));
endproperty
a_a_oe: assert property (p_a_oe) else $error("port A enable wrong");
property p_b_oe;
    rdy |-> o_port_b_oe_n == ~$past((sa_ff[15:8] & i_per_b_oe) | (~sa_ff[15:8] & pb_ff[15:8]));
endproperty
a_b_oe: assert property (p_b_oe) else $error("port B enable wrong");
property p_b_pin;
    rdy |-> ((o_port_b_pin ^ $past((sa_ff[15:8] & i_per_b_out) | (~sa_ff[15:8] & pb_ff[7:0])))
        & ~o_port_b_oe_n) == 8'h00;
endproperty
a_b_pin: assert property (p_b_pin) else $error("port B value wrong");
property p_c_oe;
    rdy |-> (o_port_c_oe_n | 8'h02) ==
        (~$past((own_c & i_per_c_oe) | (~own_c & pc_ff[15:8])) | 8'h02);
endproperty
a_c_oe: assert property (p_c_oe) else $error("port C enable wrong");
property p_c_pin;
    rdy |-> ((o_port_c_pin ^ $past((own_c & i_per_c_out) | (~own_c & pc_ff[7:0])))
        & ~o_port_c_oe_n & 8'hfd) == 8'h00;
endproperty
a_c_pin: assert property (p_c_pin) else $error("port C value wrong");
property p_c1_drive;
    (i_clock_output_selector != 2'b00) [*2] |-> !o_port_c_oe_n[1];
endproperty
a_c1_drive: assert property (p_c1_drive) else $error("clock pin not driven");
sequence s_sel_hold; (i_clock_output_selector != 2'b00 && $stable(i_clock_output_selector)) [*4];
endsequence
property p_c1_clk;
    s_sel_hold |-> o_port_c_pin[1] == $past(clk_pick, 3);
endproperty
a_c1_clk: assert property (p_c1_clk) else $error("clock pin source wrong");
endmodule // spm_gpio_properties
bind spm_gpio spm_gpio_properties u_props (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr_en,
    .i_rd_en, .o_rdata, .i_clock_output_selector, .i_watchdog_clock, .i_system_clock,
    .i_cpu_clock, .o_port_a_oe_n, .i_port_b_pin, .o_port_b_pin, .o_port_b_oe_n, .o_port_c_pin,
    .o_port_c_oe_n, .i_per_a_oe, .i_per_b_out, .i_per_b_oe, .o_per_b_in, .i_per_c_oe,
    .i_port_a_pin, .o_per_a_in, .i_port_c_pin, .i_per_c_out, .o_per_c_in);

// ### test/spm_periph_model.sv
// Model of the peripherals that share the port pins.
`timescale 1ns/100ps
module spm_periph_model
(
    input wire i_clock,
    output wire [3:0] o_a_out,
    output wire [3:0] o_a_oe,
    output wire [7:0] o_b_out,
    output wire [7:0] o_b_oe,
    output wire [7:0] o_c_out,
    output wire [7:0] o_c_oe
);
// Drive values change every cycle; enables are held constant per pin.
reg [7:0] cnt_ff = 8'h00;
always @(posedge i_clock) #1 cnt_ff = cnt_ff + 8'h01;
assign o_a_out = cnt_ff[3:0];
assign o_b_out = cnt_ff;
assign o_c_out = ~cnt_ff;
assign o_a_oe = 4'h0;
assign o_b_oe = 8'h3f;
assign o_c_oe = 8'h05;
endmodule // spm_periph_model

// ### test/tb_top.sv
// Self-checking bench for the shared pin mux block.
`timescale 1ns/100ps
`include "spm_gpio_consts.vh"
module tb_top;
reg clock = 1'b0;
reg rst_n = 1'b0;
reg [15:0] addr = 16'h0000;
reg [15:0] wdata = 16'h0000;
reg wr = 1'b0;
reg rd = 1'b0;
reg [1:0] csel = 2'b00;
reg [3:0] div = 4'h0;
reg [3:0] ext_a = 4'h5;
reg [7:0] ext_b = 8'h3c;
reg [7:0] ext_c = 8'h99;
wire [15:0] rdata;
wire [3:0] pa_o, pa_n, pera_o, pera_e;
wire [7:0] pb_o, pb_n, perb_o, perb_e, pc_o, pc_n, perc_o, perc_e;
integer mismatches = 0;
integer checks_done = 0;
integer i;
wire [3:0] pa_i = (~pa_n & pa_o) | (pa_n & ext_a);
wire [7:0] pb_i = (~pb_n & pb_o) | (pb_n & ext_b);
wire [7:0] pc_i = (~pc_n & pc_o) | (pc_n & ext_c);
spm_gpio dut (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr_en(wr),
    .i_rd_en(rd), .o_rdata(rdata), .i_clock_output_selector(csel), .i_watchdog_clock(div[3]),
    .i_system_clock(div[2]), .i_cpu_clock(div[1]), .i_port_a_pin(pa_i), .o_port_a_pin(pa_o),
    .o_port_a_oe_n(pa_n), .i_port_b_pin(pb_i), .o_port_b_pin(pb_o), .o_port_b_oe_n(pb_n),
    .i_port_c_pin(pc_i), .o_port_c_pin(pc_o), .o_port_c_oe_n(pc_n), .i_per_a_out(pera_o),
    .i_per_a_oe(pera_e), .o_per_a_in(), .i_per_b_out(perb_o), .i_per_b_oe(perb_e),
    .o_per_b_in(), .i_per_c_out(perc_o), .i_per_c_oe(perc_e), .o_per_c_in());
spm_periph_model u_per (.i_clock(clock), .o_a_out(pera_o), .o_a_oe(pera_e), .o_b_out(perb_o),
    .o_b_oe(perb_e), .o_c_out(perc_o), .o_c_oe(perc_e));
initial forever #50 clock = ~clock;
always @(posedge clock) #1 div = div + 4'h1;
////////////////////////////////////////////////////////////////////////////////
task chk(input string name, input [15:0] exp, input [15:0] got);
begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
        mismatches = mismatches + 1;
        $display("FAIL %s expected %h seen %h", name, exp, got);
    end
end
endtask
task settle;
begin
    repeat (3) @(posedge clock);
    #1;
end
endtask
task wrt(input [15:0] a, input [15:0] d);
begin
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clock);
    #1 wr = 1'b0;
    @(posedge clock);
    #1;
end
endtask
task rdc(input string name, input [15:0] a, input [15:0] exp);
begin
    addr = a;
    rd = 1'b1;
    @(posedge clock);
    #1 rd = 1'b0;
    chk(name, exp, rdata);
    @(posedge clock);
    #1;
end
endtask
task mux_c(input [15:0] s, input [7:0] exp);
begin
    wrt(`SPM_ADDR_SELECT_B, s);
    settle;
    chk("port_c_oe_n", {8'h00, exp}, {8'h00, pc_n});
end
endtask
task conclude;
begin
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
end
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    #500000;
    mismatches = mismatches + 1;
    conclude;
end
initial
begin
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    settle;
    rdc("select_a", `SPM_ADDR_SELECT_A, 16'h0000);
    rdc("select_b", `SPM_ADDR_SELECT_B, 16'h0000);
    rdc("port_a", `SPM_ADDR_PORT_A, 16'h0005);
    rdc("port_b", `SPM_ADDR_PORT_B, 16'h003c);
    chk("port_a_oe_n", 16'h000f, {12'h000, pa_n});
    chk("port_c_oe_n", 16'h00fb, {8'h00, pc_n});
    wrt(16'h7094, 16'hffff);
    rdc("unmapped", 16'h7094, 16'h0000);
    rdc("select_a", `SPM_ADDR_SELECT_A, 16'h0000);
    wrt(`SPM_ADDR_SELECT_A, 16'hffff);
    rdc("select_a", `SPM_ADDR_SELECT_A, 16'hffff);
    wrt(`SPM_ADDR_PORT_A, 16'hffff);
    rdc("port_a", `SPM_ADDR_PORT_A, 16'h0f0f);
    settle;
    chk("port_a_oe_n", 16'h000f, {12'h000, pa_n});
    chk("port_b_oe_n", 16'h00c0, {8'h00, pb_n});
    wrt(`SPM_ADDR_SELECT_A, 16'h0000);
    wrt(`SPM_ADDR_PORT_B, 16'hf0a5);
    settle;
    chk("port_a_oe_n", 16'h0000, {12'h000, pa_n});
    chk("port_a_pin", 16'h000f, {12'h000, pa_o});
    chk("port_b_oe_n", 16'h000f, {8'h00, pb_n});
    chk("port_b_pin", 16'h000a, {12'h000, pb_o[7:4]});
    rdc("port_b", `SPM_ADDR_PORT_B, 16'hf0ac);
    ext_b = 8'h35;
    settle;
    rdc("port_b", `SPM_ADDR_PORT_B, 16'hf0a5);
    wrt(`SPM_ADDR_PORT_C, 16'hff55);
    mux_c(16'h000c, 8'h00);
    chk("port_c_pin", 16'h0055, {8'h00, pc_o & 8'hfd});
    mux_c(16'h0000, 8'h08);
    mux_c(16'h00f3, 8'hf8);
    wrt(`SPM_ADDR_SELECT_B, 16'hffff);
    rdc("select_b", `SPM_ADDR_SELECT_B, 16'hffff);
    wrt(`SPM_ADDR_PORT_C, 16'h0000);
    settle;
    chk("port_c_oe_n", 16'h00fe, {8'h00, pc_n});
    for (i = 1; i < 4; i = i + 1)
    begin
        csel = i[1:0];
        repeat (8) @(posedge clock);
        #1;
        chk("clock_pin_oe_n", 16'h00fc, {8'h00, pc_n});
    end
    conclude;
end
endmodule // tb_top
